// ===== gpio_pkg.sv
// Package with register map, field positions and reset values of the dual GPIO port.
package gpio_pkg;

    typedef logic [31:0] wb_data_t;
    typedef logic [7:0] wb_addr_t;
    typedef logic [3:0] wb_sel_t;
    typedef logic [5:0] porta_t;
    typedef logic [7:0] portb_t;

    localparam int unsigned PORTA_W = 6;
    localparam int unsigned PORTB_W = 8;

    localparam wb_addr_t OFF_PORTA_DATA = 8'h00;
    localparam wb_addr_t OFF_PORTA_DIR = 8'h04;
    localparam wb_addr_t OFF_PORTA_PUE = 8'h08;
    localparam wb_addr_t OFF_PORTB_DATA = 8'h0C;
    localparam wb_addr_t OFF_PORTB_DIR = 8'h10;
    localparam wb_addr_t OFF_PORTB_PUE = 8'h14;
    localparam wb_addr_t OFF_CONFIG = 8'h18;

    localparam int unsigned CFG_CLKOUT_BIT = 0;
    localparam int unsigned CFG_IRQ_BIT = 1;
    localparam int unsigned CFG_RST_BIT = 2;

    localparam int unsigned PIN_IRQ = 2;
    localparam int unsigned PIN_RST = 3;
    localparam int unsigned PIN_CLKOUT = 4;

    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam porta_t PORTA_DIR_RESET = 6'h00;
    localparam portb_t PORTB_DIR_RESET = 8'h00;
    localparam porta_t PORTA_PUE_RESET = 6'h00;
    localparam portb_t PORTB_PUE_RESET = 8'h00;
    localparam porta_t PORTA_INPUT_ONLY = 6'h04;
    localparam porta_t PORTA_RST_MASK = 6'h08;
    localparam porta_t PORTA_CLKOUT_MASK = 6'h10;

endpackage : gpio_pkg

// ===== port_bank_if.sv
// Interface between the bus decoder and one GPIO port bank.
`timescale 1ns/1ps
interface port_bank_if #(parameter int unsigned W = 8);
    logic [W-1:0] wr_data;
    logic we_latch;
    logic we_dir;
    logic we_pue;
    logic [W-1:0] force_in;
    logic [W-1:0] alt_en;
    logic [W-1:0] alt_val;
    logic [W-1:0] pin_in;
    logic [W-1:0] rd_data;
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] pue;
    logic [W-1:0] pin_out;
    logic [W-1:0] drv_n;
    logic [W-1:0] pull_up;

    modport bank (
        input wr_data, we_latch, we_dir, we_pue, force_in, alt_en, alt_val, pin_in,
        output rd_data, latch, dir, pue, pin_out, drv_n, pull_up
    );
    modport ctrl (
        output wr_data, we_latch, we_dir, we_pue, force_in, alt_en, alt_val, pin_in,
        input rd_data, latch, dir, pue, pin_out, drv_n, pull_up
    );
endinterface : port_bank_if

// ===== port_bank.sv
// One GPIO port: data latch, direction, pullup enable and registered pin drivers.
`timescale 1ns/1ps
module port_bank #(
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    port_bank_if.bank bus
);

    logic [W-1:0] latch_reg;
    logic [W-1:0] dir_reg;
    logic [W-1:0] pue_reg;
    logic [W-1:0] latch_next;
    logic [W-1:0] dir_next;
    logic [W-1:0] pue_next;
    logic [W-1:0] pin_out_reg;
    logic [W-1:0] drv_n_reg;
    logic [W-1:0] pull_up_reg;

    assign latch_next = bus.we_latch ? bus.wr_data : latch_reg;
    assign dir_next = bus.we_dir ? bus.wr_data : dir_reg;
    assign pue_next = bus.we_pue ? bus.wr_data : pue_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // The data latch has no reset and takes every write whatever the direction.
    always_ff @(posedge clk_i) begin
        latch_reg <= latch_next;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dir_reg <= '0;
        end else begin
            dir_reg <= dir_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pue_reg <= '0;
        end else begin
            pue_reg <= pue_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers follow the new register values at the edge of the write.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_reg <= '0;
            drv_n_reg <= '1;
            pull_up_reg <= '0;
        end else begin
            pin_out_reg <= (bus.alt_en & bus.alt_val) | (~bus.alt_en & latch_next);
            drv_n_reg <= ~(bus.alt_en | (dir_next & ~bus.force_in));
            pull_up_reg <= pue_next & ~dir_next & ~bus.alt_en;
        end
    end

    assign bus.rd_data = (dir_reg & latch_reg) | (~dir_reg & bus.pin_in);
    assign bus.latch = latch_reg;
    assign bus.dir = dir_reg;
    assign bus.pue = pue_reg;
    assign bus.pin_out = pin_out_reg;
    assign bus.drv_n = drv_n_reg;
    assign bus.pull_up = pull_up_reg;

endmodule : port_bank

// ===== gpio_dual_port.sv
// Dual GPIO port with a classic Wishbone register slave.
//
// Overview of operation
// - Port A data read gives latch for outputs, live pin for inputs.
// - Port B data read gives latch for outputs, live pin for inputs.
// - Data writes always update the latch; input reads stay the pin level.
// - Port A pullups switch off whenever the pin is an output.
// - Port A pullup bit 1 connects pullup on inputs; 0 always disconnects.
// - With internal or RC oscillator, clock-out enable drives the fast clock on pin four.
// - Clock-out enable does nothing when crystal or external clock is selected.
// - The port A input-only pin never drives, whatever its direction bit.
// - Port B has eight pins, each with latch, direction and pullup bits.
// - Reset clears every port B direction bit, making all pins inputs.
// - Reset leaves the port B data latch unchanged; it has no reset value.
// - Port B pullup bit 1 connects pullup on inputs; 0 always disconnects.
// - Port B pullups turn off at once when the pin is an output.
// - Reset and interrupt pins start as plain port pins until configured.
// - Reset clears all six port A direction bits, making all pins inputs.
// - Direction bit 1 enables the output buffer, 0 disables it.
// - With the interrupt function on, port A data bit two reads 0.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module gpio_dual_port (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire gpio_pkg::wb_addr_t wb_adr_i,
    input wire gpio_pkg::wb_sel_t wb_sel_i,
    input wire gpio_pkg::wb_data_t wb_dat_i,
    output gpio_pkg::wb_data_t wb_dat_o,
    output logic wb_ack_o,
    input wire gpio_pkg::porta_t porta_pin_i,
    output gpio_pkg::porta_t porta_pin_o,
    output gpio_pkg::porta_t porta_pin_oe_n_o,
    output gpio_pkg::porta_t porta_pullup_o,
    input wire gpio_pkg::portb_t portb_pin_i,
    output gpio_pkg::portb_t portb_pin_o,
    output gpio_pkg::portb_t portb_pin_oe_n_o,
    output gpio_pkg::portb_t portb_pullup_o,
    input wire logic osc_int_or_rc_i,
    input wire logic quad_bus_clock_i,
    output logic irq_func_en_o,
    output logic rst_func_en_o
);
    import gpio_pkg::*;

    port_bank_if #(.W(PORTA_W)) a_if ();
    port_bank_if #(.W(PORTB_W)) b_if ();

    logic req;
    logic wr;
    logic rd;
    logic ack_reg;
    wb_data_t dat_reg;
    wb_data_t dat_next;
    logic [2:0] cfg_reg;
    logic clkout_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode: a request is taken in the first cycle and acked one cycle later.
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_comb begin
        dat_next = '0;
        case (wb_adr_i)
            OFF_PORTA_DATA: begin
                dat_next[PORTA_W-1:0] = a_if.rd_data;
                if (cfg_reg[CFG_IRQ_BIT]) begin
                    dat_next[PIN_IRQ] = 1'b0;
                end
            end
            OFF_PORTA_DIR: begin
                dat_next[PORTA_W-1:0] = a_if.dir;
            end
            OFF_PORTA_PUE: begin
                dat_next[PORTA_W-1:0] = a_if.pue;
            end
            OFF_PORTB_DATA: begin
                dat_next[PORTB_W-1:0] = b_if.rd_data;
            end
            OFF_PORTB_DIR: begin
                dat_next[PORTB_W-1:0] = b_if.dir;
            end
            OFF_PORTB_PUE: begin
                dat_next[PORTB_W-1:0] = b_if.pue;
            end
            OFF_CONFIG: begin
                dat_next[2:0] = cfg_reg;
            end
            default: begin
                dat_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dat_reg <= '0;
        end else if (rd) begin
            dat_reg <= dat_next;
        end else begin
            dat_reg <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration register: clock-out, interrupt and reset pin functions.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_reg <= CONFIG_RESET;
        end else if (wr && wb_adr_i == OFF_CONFIG) begin
            cfg_reg <= wb_dat_i[2:0];
        end
    end

    assign clkout_active = cfg_reg[CFG_CLKOUT_BIT] && osc_int_or_rc_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Port banks.
    assign a_if.wr_data = wb_dat_i[PORTA_W-1:0];
    assign a_if.we_latch = wr && wb_adr_i == OFF_PORTA_DATA;
    assign a_if.we_dir = wr && wb_adr_i == OFF_PORTA_DIR;
    assign a_if.we_pue = wr && wb_adr_i == OFF_PORTA_PUE;
    assign a_if.force_in = PORTA_INPUT_ONLY | (cfg_reg[CFG_RST_BIT] ? PORTA_RST_MASK : '0);
    assign a_if.alt_en = clkout_active ? PORTA_CLKOUT_MASK : '0;
    assign a_if.alt_val = quad_bus_clock_i ? PORTA_CLKOUT_MASK : '0;
    assign a_if.pin_in = porta_pin_i;

    assign b_if.wr_data = wb_dat_i[PORTB_W-1:0];
    assign b_if.we_latch = wr && wb_adr_i == OFF_PORTB_DATA;
    assign b_if.we_dir = wr && wb_adr_i == OFF_PORTB_DIR;
    assign b_if.we_pue = wr && wb_adr_i == OFF_PORTB_PUE;
    assign b_if.force_in = '0;
    assign b_if.alt_en = '0;
    assign b_if.alt_val = '0;
    assign b_if.pin_in = portb_pin_i;

    port_bank #(.W(PORTA_W)) u_porta (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .bus(a_if.bank)
    );

    port_bank #(.W(PORTB_W)) u_portb (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .bus(b_if.bank)
    );

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign porta_pin_o = a_if.pin_out;
    assign porta_pin_oe_n_o = a_if.drv_n;
    assign porta_pullup_o = a_if.pull_up;
    assign portb_pin_o = b_if.pin_out;
    assign portb_pin_oe_n_o = b_if.drv_n;
    assign portb_pullup_o = b_if.pull_up;
    assign irq_func_en_o = cfg_reg[CFG_IRQ_BIT];
    assign rst_func_en_o = cfg_reg[CFG_RST_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_wr_b_dir;
        wr && wb_adr_i == OFF_PORTB_DIR;
    endsequence

    sequence s_wr_b_data;
        wr && wb_adr_i == OFF_PORTB_DATA;
    endsequence

    sequence s_rd_a_irq;
        rd && wb_adr_i == OFF_PORTA_DATA && cfg_reg[CFG_IRQ_BIT];
    endsequence

    sequence s_rd_a_plain;
        rd && wb_adr_i == OFF_PORTA_DATA && !cfg_reg[CFG_IRQ_BIT];
    endsequence

    sequence s_wr_a_dir;
        wr && wb_adr_i == OFF_PORTA_DIR;
    endsequence

    sequence s_wr_a_data;
        wr && wb_adr_i == OFF_PORTA_DATA;
    endsequence

    sequence s_wr_a_pue;
        wr && wb_adr_i == OFF_PORTA_PUE;
    endsequence

    sequence s_wr_b_pue;
        wr && wb_adr_i == OFF_PORTB_PUE;
    endsequence

    sequence s_bus_take;
        req;
    endsequence

    // Reset state.
    a_reset_b_inputs: assert property (@(posedge clk_i) $rose(arst_n_i) |-> portb_pin_oe_n_o == 8'hFF)
        else $error("port B pin driven right after reset");
    a_reset_a_inputs: assert property (@(posedge clk_i) $rose(arst_n_i) |-> porta_pin_oe_n_o == 6'h3F)
        else $error("port A pin driven right after reset");
    a_reset_pins_plain: assert property (@(posedge clk_i)
        $rose(arst_n_i) |-> !irq_func_en_o && !rst_func_en_o)
        else $error("pin functions active right after reset");

    // Bus handshake.
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_bus_take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a one-cycle pulse");
    a_ack_after_req: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wb_ack_o |-> $past(req))
        else $error("ack without a request");
    a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_high_bits_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_bus_take |=> wb_dat_o[31:8] == 24'h0)
        else $error("unused read data bits not zero");

    // Register writes.
    a_dir_b_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_b_dir |=> portb_pin_oe_n_o == ~$past(wb_dat_i[7:0]) && wb_ack_o)
        else $error("port B direction write not on pins");
    a_dir_a_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_a_dir |=> (porta_pin_oe_n_o | $past(a_if.force_in | a_if.alt_en))
        == ($past(~wb_dat_i[5:0]) | $past(a_if.force_in | a_if.alt_en)))
        else $error("port A direction write not on pins");
    a_dir_a_reg: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_a_dir |=> a_if.dir == $past(wb_dat_i[5:0]))
        else $error("port A direction register not written");
    a_latch_b_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_b_data |=> b_if.latch == $past(wb_dat_i[7:0]))
        else $error("port B latch not written");
    a_latch_a_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_a_data |=> a_if.latch == $past(wb_dat_i[5:0]))
        else $error("port A latch not written");
    a_pue_b_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_b_pue |=> portb_pullup_o == $past(wb_dat_i[7:0] & ~b_if.dir))
        else $error("port B pullup write not on pins");
    a_pue_a_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_wr_a_pue |=> porta_pullup_o == $past(wb_dat_i[5:0] & ~a_if.dir & ~a_if.alt_en))
        else $error("port A pullup write not on pins");
    a_cfg_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr && wb_adr_i == OFF_CONFIG |=> {rst_func_en_o, irq_func_en_o} == $past(wb_dat_i[2:1]))
        else $error("pin function enables not written");

    // Reads.
    a_read_b_mux: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd && wb_adr_i == OFF_PORTB_DATA
        |=> wb_dat_o[7:0] == (($past(b_if.dir) & $past(b_if.latch)) | (~$past(b_if.dir) & $past(portb_pin_i))))
        else $error("port B read mux wrong");
    a_read_a_mux: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_rd_a_plain
        |=> wb_dat_o[5:0] == (($past(a_if.dir) & $past(a_if.latch)) | (~$past(a_if.dir) & $past(porta_pin_i))))
        else $error("port A read mux wrong");
    a_read_a_irq: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_rd_a_irq |=> !wb_dat_o[PIN_IRQ] ##1 !wb_ack_o)
        else $error("port A bit two not zero with interrupt on");

    // Pins and pullups.
    a_input_only_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i) porta_pin_oe_n_o[PIN_IRQ])
        else $error("input-only pin is driven");
    a_rst_pin_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rst_func_en_o && $past(rst_func_en_o) |-> porta_pin_oe_n_o[PIN_RST])
        else $error("reset function pin is driven");
    a_pullup_b_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (portb_pullup_o & ~portb_pin_oe_n_o) == 8'h00)
        else $error("port B pullup on a driven pin");
    a_pullup_a_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (porta_pullup_o & ~porta_pin_oe_n_o) == 6'h00)
        else $error("port A pullup on a driven pin");
    a_pullup_b_track: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !b_if.we_dir && !b_if.we_pue |=> portb_pullup_o == $past(b_if.pue & ~b_if.dir))
        else $error("port B pullup does not follow its registers");
    a_pullup_a_track: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !a_if.we_dir && !a_if.we_pue |=> porta_pullup_o == $past(a_if.pue & ~a_if.dir & ~a_if.alt_en))
        else $error("port A pullup does not follow its registers");

    // Clock-out pin.
    a_clkout_xtal: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !osc_int_or_rc_i && !a_if.we_dir |=> porta_pin_oe_n_o[PIN_CLKOUT] == !$past(a_if.dir[PIN_CLKOUT]))
        else $error("clock-out acts under crystal option");
    a_clkout_drive: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        clkout_active |=> !porta_pin_oe_n_o[PIN_CLKOUT] && !porta_pullup_o[PIN_CLKOUT])
        else $error("clock-out pin not driven");
    a_clkout_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        clkout_active |=> porta_pin_o[PIN_CLKOUT] == $past(quad_bus_clock_i))
        else $error("clock-out pin does not carry the fast clock");

endmodule : gpio_dual_port

// ===== gpio_board_model.sv
// Board circuitry model that resolves the level of every port pin.
`timescale 1ns/1ps
module gpio_board_model #(
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] oe_n_i,
    input wire logic [W-1:0] pullup_i,
    input wire logic [W-1:0] ext_i,
    input wire logic [W-1:0] ext_en_i,
    output logic [W-1:0] pin_o
);
    logic tgl_reg = 1'b0;
    // A floating pin with no pullup changes level every cycle.
    always_ff @(posedge clk_i) begin
        tgl_reg <= ~tgl_reg;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_o[i] = !oe_n_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] : pullup_i[i] ? 1'b1 : tgl_reg;
        end
    end
endmodule : gpio_board_model

// ===== gpio_dual_port_tb.sv
// Self-checking bench for the dual GPIO port with a reference model of both ports.
`timescale 1ns/1ps
module gpio_dual_port_tb;
    import gpio_pkg::*;
    logic clk_i, arst_n_i, cyc, stb, we, osc, qclk, wb_ack_o, irq_en, rst_en;
    wb_addr_t adr;
    wb_sel_t sel;
    wb_data_t dat_w, wb_dat_o, r;
    porta_t pa_pin, pa_o, pa_oen, pa_pu, pa_ext, pa_een;
    portb_t pb_pin, pb_o, pb_oen, pb_pu, pb_ext, pb_een;
    logic [7:0] m_lat[2], m_dir[2], m_pue[2];
    logic [2:0] m_cfg;
    int miscompares, checks;
    wb_addr_t regs[6] = '{OFF_PORTA_DIR, OFF_PORTA_PUE, OFF_PORTB_DIR, OFF_PORTB_PUE, OFF_CONFIG, 8'h1C};

    gpio_dual_port DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .porta_pin_i(pa_pin), .porta_pin_o(pa_o), .porta_pin_oe_n_o(pa_oen), .porta_pullup_o(pa_pu),
        .portb_pin_i(pb_pin), .portb_pin_o(pb_o), .portb_pin_oe_n_o(pb_oen), .portb_pullup_o(pb_pu),
        .osc_int_or_rc_i(osc), .quad_bus_clock_i(qclk), .irq_func_en_o(irq_en), .rst_func_en_o(rst_en));
    gpio_board_model #(.W(6)) board_a (.clk_i(clk_i), .drv_i(pa_o), .oe_n_i(pa_oen), .pullup_i(pa_pu),
        .ext_i(pa_ext), .ext_en_i(pa_een), .pin_o(pa_pin));
    gpio_board_model #(.W(8)) board_b (.clk_i(clk_i), .drv_i(pb_o), .oe_n_i(pb_oen), .pullup_i(pb_pu),
        .ext_i(pb_ext), .ext_en_i(pb_een), .pin_o(pb_pin));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task end_sim;
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task chk(input wb_data_t seen, input wb_data_t exp, input wb_data_t mask);
        checks++;
        if ((seen & mask) !== (exp & mask)) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wb(input logic w, input wb_addr_t a, input wb_data_t d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        chk(32'(n), 32'h2, '1);
        if (n >= 20) end_sim();
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task wr(input wb_addr_t a, input wb_data_t d);
        wb(1'b1, a, d);
        case (a)
            OFF_PORTA_DATA: m_lat[0] = 8'(d[5:0]);
            OFF_PORTA_DIR: m_dir[0] = 8'(d[5:0]);
            OFF_PORTA_PUE: m_pue[0] = 8'(d[5:0]);
            OFF_PORTB_DATA: m_lat[1] = d[7:0];
            OFF_PORTB_DIR: m_dir[1] = d[7:0];
            OFF_PORTB_PUE: m_pue[1] = d[7:0];
            OFF_CONFIG: m_cfg = d[2:0];
            default: ;
        endcase
    endtask : wr

    function automatic wb_data_t reg_exp(input wb_addr_t a);
        case (a)
            OFF_PORTA_DIR: return 32'(m_dir[0]);
            OFF_PORTA_PUE: return 32'(m_pue[0]);
            OFF_PORTB_DIR: return 32'(m_dir[1]);
            OFF_PORTB_PUE: return 32'(m_pue[1]);
            OFF_CONFIG: return 32'(m_cfg);
            default: return 32'h0;
        endcase
    endfunction : reg_exp

    task chk_port(input int p);
        logic [7:0] oen, pu, dv, lvl, een, ext, rm, rv, msk;
        logic ck;
        ck = (p == 0) && m_cfg[CFG_CLKOUT_BIT] && osc;
        oen = ~m_dir[p];
        pu = m_pue[p] & ~m_dir[p];
        dv = m_lat[p];
        msk = p ? 8'hFF : 8'h3F;
        een = p ? pb_een : 8'(pa_een);
        ext = p ? pb_ext : 8'(pa_ext);
        if (p == 0) begin
            oen[PIN_IRQ] = 1'b1;
            if (m_cfg[CFG_RST_BIT]) begin
                oen[PIN_RST] = 1'b1;
            end
            if (ck) begin
                oen[PIN_CLKOUT] = 1'b0;
                pu[PIN_CLKOUT] = 1'b0;
                dv[PIN_CLKOUT] = qclk;
            end
        end
        for (int i = 0; i < 8; i++) begin
            lvl[i] = !oen[i] ? dv[i] : een[i] ? ext[i] : pu[i];
            rm[i] = m_dir[p][i] | !oen[i] | een[i] | pu[i];
            rv[i] = m_dir[p][i] ? m_lat[p][i] : lvl[i];
        end
        if (p == 0 && m_cfg[CFG_IRQ_BIT]) begin
            rv[PIN_IRQ] = 1'b0;
            rm[PIN_IRQ] = 1'b1;
        end
        wb(1'b0, p ? OFF_PORTB_DATA : OFF_PORTA_DATA, 32'h0);
        chk(r, 32'(rv), 32'(rm & msk));
        chk(32'(p ? pb_oen : pa_oen), 32'(oen), 32'(msk));
        chk(32'(p ? pb_pu : pa_pu), 32'(pu), 32'(msk));
        chk(32'(p ? pb_o : pa_o), 32'(dv), 32'(~oen & msk));
    endtask : chk_port

    task chk_regs;
        foreach (regs[i]) begin
            wb(1'b0, regs[i], 32'h0);
            chk(r, reg_exp(regs[i]), '1);
        end
        chk(32'({rst_en, irq_en}), 32'(m_cfg[2:1]), '1);
    endtask : chk_regs

    initial begin
        {cyc, stb, we, osc, qclk} = '0;
        {adr, sel, dat_w, pa_ext, pa_een, pb_ext, pb_een} = '0;
        arst_n_i = 1'b0;
        miscompares = 0;
        checks = 0;
        m_lat = '{8'hXX, 8'hXX};
        m_dir = '{8'h00, 8'h00};
        m_pue = '{8'h00, 8'h00};
        m_cfg = 3'h0;
        void'($urandom(32'h13C0F034));
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        chk_regs();
        chk_port(0);
        chk_port(1);
        for (int k = 0; k < 40; k++) begin
            pa_ext <= porta_t'($urandom);
            pa_een <= porta_t'($urandom);
            pb_ext <= portb_t'($urandom);
            pb_een <= portb_t'($urandom);
            osc <= 1'($urandom);
            qclk <= 1'($urandom);
            // Latch first, then direction, so a pin never shows a stale level.
            wr(OFF_PORTA_DATA, $urandom);
            wr(OFF_PORTB_DATA, $urandom);
            wr(OFF_PORTA_PUE, $urandom);
            wr(OFF_PORTB_PUE, $urandom);
            wr(OFF_PORTA_DIR, $urandom);
            wr(OFF_PORTB_DIR, $urandom);
            wr(OFF_CONFIG, $urandom);
            chk_port(0);
            chk_port(1);
            chk_regs();
        end
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        m_dir = '{8'h00, 8'h00};
        m_pue = '{8'h00, 8'h00};
        m_cfg = 3'h0;
        chk_regs();
        wr(OFF_PORTB_DIR, 32'hFF);
        chk_port(1);
        end_sim();
    end
endmodule : gpio_dual_port_tb
